// ### rcs_route_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
//
// Overview of operation
// - crosspoint per path per sixteen buses
// - paths include stereo returns plus channels
// - rests idle after reset, no selection
// - crosspoints change only in selection, clear excepted
// - selected paths or buses flash blue
// - idle path key selects path, flashes it
// - selected path plus bus key routes, bright
// - further bus keys add further crosspoints
// - selected path key again returns idle
// - idle: routed buses and paths lit dim
// - two bus keys act on inclusive range
// - two path keys select inclusive range
// - range selected routes every path every bus
// - range ends by same pair or shift
// - shift cancels selection, returns idle unchanged
// - shift held plus key clears its routes
// - idle bus key selects bus, paths toggle
// - selected bus flashes, routed paths bright
module rcs_route_ctrl
  import rcs_pkg::*;
#(
  parameter int DEB_COUNT   = rcs_pkg::DEB_CYC,
  parameter int FLASH_COUNT = rcs_pkg::FLASH_CYC
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic [rcs_pkg::NUM_PATH-1:0] path_key_raw,
  input  wire logic [rcs_pkg::NUM_BUS-1:0]  bus_key_raw,
  input  wire logic                     shift_key_raw,
  output logic [rcs_pkg::NUM_PATH-1:0]      path_assigned_indicator,
  output logic [rcs_pkg::NUM_BUS-1:0]       bus_led,
  output logic [rcs_pkg::NUM_PATH*rcs_pkg::NUM_BUS-1:0] xpoint
);
  import rcs_pkg::*;

  localparam int FW = $clog2(FLASH_COUNT + 1);

  logic [NUM_PATH-1:0] p_lvl, p_prs;
  logic [NUM_BUS-1:0]  b_lvl, b_prs;
  logic                s_lvl, s_prs;

  // debounce all front-panel keys through one shared module
  rcs_key_debounce #(
    .N     (NUM_PATH + NUM_BUS + 1),
    .COUNT (DEB_COUNT)
  ) u_deb (
    .clock     (clock),
    .rst       (rst),
    .key_raw   ({shift_key_raw, bus_key_raw, path_key_raw}),
    .key_level ({s_lvl, b_lvl, p_lvl}),
    .key_press ({s_prs, b_prs, p_prs})
  );

  // lowest set bit index
  function automatic int lowest(input logic [NUM_PATH-1:0] v, input int n);
    int r;
    r = 0;
    for (int i = n - 1; i >= 0; i--) begin
      if (v[i]) r = i;
    end
    return r;
  endfunction : lowest

  // inclusive mask from an anchor key to a newly pressed key
  function automatic logic [NUM_PATH-1:0] span(input int a, input int b);
    logic [NUM_PATH-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_PATH; i++) begin
      if ((i >= a && i <= b) || (i >= b && i <= a)) m[i] = 1'b1;
    end
    return m;
  endfunction : span

  // routing matrix, one word per path
  logic [NUM_BUS-1:0] xp_q [NUM_PATH];
  rcs_mode_t          mode_q;
  logic [NUM_PATH-1:0] psel_q;
  logic [NUM_BUS-1:0]  bsel_q;
  // range anchors for simultaneous presses
  logic [PATH_IDX_W-1:0] p_anchor_q;
  logic                  p_anchor_v_q;
  logic [BUS_IDX_W-1:0]  b_anchor_q;
  logic                  b_anchor_v_q;
  logic [NUM_PATH-1:0]   p_range_q;
  logic                  p_is_range_q;
  logic [NUM_BUS-1:0]    b_range_q;
  logic                  b_is_range_q;

  // effective press masks with range expansion
  logic [NUM_PATH-1:0] p_act;
  logic [NUM_BUS-1:0]  b_act;
  logic                p_second, b_second;
  logic [NUM_PATH-1:0] p_span_full;
  logic [NUM_PATH-1:0] b_span_full;
  int                  p_new, b_new;

  // resolve a press into a single key or an inclusive range
  always_comb begin
    p_new       = lowest(p_prs, NUM_PATH);
    b_new       = lowest({{(NUM_PATH-NUM_BUS){1'b0}}, b_prs}, NUM_BUS);
    p_second    = |p_prs && p_anchor_v_q && p_lvl[p_anchor_q];
    b_second    = |b_prs && b_anchor_v_q && b_lvl[b_anchor_q];
    p_span_full = span(int'(p_anchor_q), p_new);
    b_span_full = span(int'(b_anchor_q), b_new);
    p_act       = p_second ? p_span_full : p_prs;
    b_act       = b_second ? b_span_full[NUM_BUS-1:0] : b_prs;
  end

  // remember the first key of a possible pair
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      p_anchor_q   <= '0;
      p_anchor_v_q <= 1'b0;
      b_anchor_q   <= '0;
      b_anchor_v_q <= 1'b0;
    end else begin
      if (|p_prs && !p_second) begin
        p_anchor_q   <= PATH_IDX_W'(p_new);
        p_anchor_v_q <= 1'b1;
      end else if (p_anchor_v_q && !p_lvl[p_anchor_q]) begin
        p_anchor_v_q <= 1'b0;
      end
      if (|b_prs && !b_second) begin
        b_anchor_q   <= BUS_IDX_W'(b_new);
        b_anchor_v_q <= 1'b1;
      end else if (b_anchor_v_q && !b_lvl[b_anchor_q]) begin
        b_anchor_v_q <= 1'b0;
      end
    end
  end

  // selection state machine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q       <= RCS_IDLE;
      psel_q       <= '0;
      bsel_q       <= '0;
      p_range_q    <= '0;
      p_is_range_q <= 1'b0;
      b_range_q    <= '0;
      b_is_range_q <= 1'b0;
    end else begin
      unique case (mode_q)
        RCS_IDLE: begin
          if (s_lvl) begin
            mode_q <= RCS_IDLE; // clear mode, no selection
          end else if (|p_act) begin
            mode_q       <= RCS_PATH_SEL;
            psel_q       <= p_act;
            p_range_q    <= p_act;
            p_is_range_q <= 1'b0;
          end else if (|b_act) begin
            mode_q       <= RCS_BUS_SEL;
            bsel_q       <= b_act;
            b_range_q    <= b_act;
            b_is_range_q <= 1'b0;
          end
        end
        RCS_PATH_SEL: begin
          if (s_prs) begin
            mode_q <= RCS_IDLE;
            psel_q <= '0;
          end else if (p_second && p_act != psel_q) begin
            psel_q       <= p_act; // widen to the pair range
            p_range_q    <= p_act;
            p_is_range_q <= 1'b1;
          end else if (|p_act && p_act == p_range_q) begin
            mode_q <= RCS_IDLE;
            psel_q <= '0;
          end
        end
        RCS_BUS_SEL: begin
          if (s_prs) begin
            mode_q <= RCS_IDLE;
            bsel_q <= '0;
          end else if (b_second && b_act != bsel_q) begin
            bsel_q       <= b_act;
            b_range_q    <= b_act;
            b_is_range_q <= 1'b1;
          end else if (|b_act && b_act == b_range_q) begin
            mode_q <= RCS_IDLE;
            bsel_q <= '0;
          end
        end
        default: begin
          mode_q <= RCS_IDLE; // a corrupted code falls back to rest
          psel_q <= '0;
          bsel_q <= '0;
        end
      endcase
    end
  end

  // row update enables, decoded once and shared by every row;
  // a shift press always wins so a cancel never edits a route
  logic row_clear_en;
  logic row_add_en;
  logic row_toggle_en;
  logic row_merge_en;
  always_comb begin
    row_clear_en  = (mode_q == RCS_IDLE) && s_lvl;
    row_add_en    = (mode_q == RCS_PATH_SEL) && !s_prs;
    row_toggle_en = (mode_q == RCS_BUS_SEL) && !s_prs && !p_second;
    row_merge_en  = (mode_q == RCS_BUS_SEL) && !s_prs && p_second;
  end

  // crosspoint storage, one row per path incl. returns
  genvar gp;
  for (gp = 0; gp < NUM_PATH; gp++) begin : g_row
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        xp_q[gp] <= '0;
      end else if (row_clear_en) begin
        if (p_act[gp]) begin
          xp_q[gp] <= '0;
        end else begin
          xp_q[gp] <= xp_q[gp] & ~b_act;
        end
      end else if (row_add_en && psel_q[gp]) begin
        xp_q[gp] <= xp_q[gp] | b_act;
      end else if (row_toggle_en && p_act[gp]) begin
        xp_q[gp] <= xp_q[gp] ^ bsel_q;
      end else if (row_merge_en && p_act[gp]) begin
        xp_q[gp] <= xp_q[gp] | bsel_q;
      end
    end
  end

  // a new selection restarts the flash so the key lights at once
  logic sel_start;
  assign sel_start = (mode_q == RCS_IDLE) && !s_lvl && ((|p_act) || (|b_act));

  // shared flash timer and dim pwm
  logic [FW-1:0]    flash_cnt_q;
  logic             flash_q;
  logic [PWM_W-1:0] pwm_q;
  logic             dim_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
      pwm_q       <= '0;
      dim_q       <= 1'b0;
    end else begin
      pwm_q <= pwm_q + 1'b1;
      dim_q <= (pwm_q < PWM_W'(DIM_ON));
      if (sel_start) begin
        flash_cnt_q <= '0; // one timer, so all flashing stays in phase
        flash_q     <= 1'b1;
      end else if (flash_cnt_q == FW'(FLASH_COUNT - 1)) begin
        flash_cnt_q <= '0;
        flash_q     <= ~flash_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 1'b1;
      end
    end
  end

  // indicator sources
  logic [NUM_BUS-1:0]  bus_any;
  logic [NUM_PATH-1:0] path_any;
  logic [NUM_BUS-1:0]  bus_of_sel;
  logic [NUM_PATH-1:0] path_to_sel;
  logic [NUM_BUS-1:0]  bus_led_d;
  logic [NUM_PATH-1:0] path_led_d;
  always_comb begin
    bus_any     = '0;
    bus_of_sel  = '0;
    path_any    = '0;
    path_to_sel = '0;
    for (int i = 0; i < NUM_PATH; i++) begin
      bus_any        = bus_any | xp_q[i];
      path_any[i]    = |xp_q[i];
      path_to_sel[i] = |(xp_q[i] & bsel_q);
      if (psel_q[i]) bus_of_sel = bus_of_sel | xp_q[i];
    end
    unique case (mode_q)
      RCS_PATH_SEL: begin
        path_led_d = psel_q & {NUM_PATH{flash_q}};
        bus_led_d  = bus_of_sel;
      end
      RCS_BUS_SEL: begin
        bus_led_d  = bsel_q & {NUM_BUS{flash_q}};
        path_led_d = path_to_sel;
      end
      default: begin
        bus_led_d  = bus_any & {NUM_BUS{dim_q}};
        path_led_d = path_any & {NUM_PATH{dim_q}};
      end
    endcase
  end

  // registered outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_led                 <= '0;
      path_assigned_indicator <= '0;
      xpoint                  <= '0;
    end else begin
      bus_led                 <= bus_led_d;
      path_assigned_indicator <= path_led_d;
      for (int i = 0; i < NUM_PATH; i++) begin
        xpoint[i*NUM_BUS +: NUM_BUS] <= xp_q[i];
      end
    end
  end
endmodule : rcs_route_ctrl
`default_nettype wire

// ### rcs_pkg.sv
`default_nettype none
package rcs_pkg;
  // geometry
  localparam int NUM_BUS     = 16;
  localparam int NUM_CHAN    = 24;
  localparam int NUM_RET     = 8;
  localparam int NUM_PATH    = NUM_CHAN + NUM_RET;
  localparam int BUS_IDX_W   = $clog2(NUM_BUS);
  localparam int PATH_IDX_W  = $clog2(NUM_PATH);
  // timing
  localparam int CLK_HZ      = 20_000_000;
  localparam int DEB_MS      = 10;
  localparam int DEB_CYC     = (CLK_HZ / 1000) * DEB_MS;
  localparam int FLASH_MS    = 250;
  localparam int FLASH_CYC   = (CLK_HZ / 1000) * FLASH_MS;
  localparam int DIM_PER     = 8;
  localparam int DIM_ON      = 1;
  localparam int PWM_W       = $clog2(DIM_PER);
  // controller modes, one-hot
  typedef enum logic [2:0] {
    RCS_IDLE     = 3'b001,
    RCS_PATH_SEL = 3'b010,
    RCS_BUS_SEL  = 3'b100
  } rcs_mode_t;
endpackage : rcs_pkg
`default_nettype wire

// ### rcs_key_debounce.sv
`timescale 1ns/10ps
`default_nettype none
// synchronises and debounces a group of keys, gives level and press pulse
module rcs_key_debounce #(
  parameter int N     = 16,
  parameter int COUNT = 200_000
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [N-1:0] key_raw,
  output logic      [N-1:0] key_level,
  output logic      [N-1:0] key_press
);
  localparam int CW = $clog2(COUNT + 1);
  logic [N-1:0] sync1_q;
  logic [N-1:0] sync2_q;

  // two-stage synchroniser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= key_raw;
      sync2_q <= sync1_q;
    end
  end

  // per-key stability counter
  genvar g;
  for (g = 0; g < N; g++) begin : g_key
    logic [CW-1:0] cnt_q;
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        cnt_q        <= '0;
        key_level[g] <= 1'b0;
        key_press[g] <= 1'b0;
      end else begin
        key_press[g] <= 1'b0;
        if (sync2_q[g] == key_level[g]) begin
          cnt_q <= '0;
        end else if (cnt_q == CW'(COUNT - 1)) begin
          cnt_q        <= '0;
          key_level[g] <= sync2_q[g];
          key_press[g] <= sync2_q[g];
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule : rcs_key_debounce
`default_nettype wire

// ### rcs_route_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the routing controller
module rcs_route_ctrl_asserts
  import rcs_pkg::*;
#(
  parameter int DEB_COUNT   = rcs_pkg::DEB_CYC,
  parameter int FLASH_COUNT = rcs_pkg::FLASH_CYC
) (
  input wire logic                          clock,
  input wire logic                          rst,
  input wire logic [rcs_pkg::NUM_PATH-1:0]  path_key_raw,
  input wire logic [rcs_pkg::NUM_BUS-1:0]   bus_key_raw,
  input wire logic                          shift_key_raw,
  input wire logic [rcs_pkg::NUM_PATH-1:0]  path_assigned_indicator,
  input wire logic [rcs_pkg::NUM_BUS-1:0]   bus_led,
  input wire logic [rcs_pkg::NUM_PATH*rcs_pkg::NUM_BUS-1:0] xpoint
);
  localparam int QUIET = DEB_COUNT + 8;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic pb_act;
  logic ps_act;
  int   pb_q;
  int   ps_q;
  int   sh_q;
  logic fresh_q;
  // key group activity
  assign pb_act = (|path_key_raw) || (|bus_key_raw);
  assign ps_act = (|path_key_raw) || shift_key_raw;
  // quiet and held cycle counts, saturating
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pb_q    <= 0;
      ps_q    <= 0;
      sh_q    <= 0;
      fresh_q <= 1'b1;
    end else begin
      pb_q    <= pb_act ? 0 : ((pb_q < QUIET) ? pb_q + 1 : pb_q);
      ps_q    <= ps_act ? 0 : ((ps_q < QUIET) ? ps_q + 1 : ps_q);
      sh_q    <= !shift_key_raw ? 0 : ((sh_q < QUIET) ? sh_q + 1 : sh_q);
      fresh_q <= fresh_q && !pb_act && !shift_key_raw;
    end
  end
  property p_rst_xp;
    $past(rst) |-> xpoint == '0;
  endproperty
  a_rst_xp: assert property (p_rst_xp)
    else $error("crosspoints not clear after reset");
  property p_rst_led;
    $past(rst) |-> bus_led == '0 && path_assigned_indicator == '0;
  endproperty
  a_rst_led: assert property (p_rst_led)
    else $error("indicators lit after reset");
  property p_fresh_xp;
    fresh_q |-> xpoint == '0;
  endproperty
  a_fresh_xp: assert property (p_fresh_xp)
    else $error("crosspoint set without any key");
  property p_fresh_led;
    fresh_q |-> bus_led == '0 && path_assigned_indicator == '0;
  endproperty
  a_fresh_led: assert property (p_fresh_led)
    else $error("indicator lit with no route and no selection");
  property p_pb_quiet;
    pb_q >= QUIET |-> $stable(xpoint);
  endproperty
  a_pb_quiet: assert property (p_pb_quiet)
    else $error("crosspoints changed with no path or bus key");
  property p_bus_adds;
    ps_q >= QUIET |-> ($past(xpoint) & ~xpoint) == '0;
  endproperty
  a_bus_adds: assert property (p_bus_adds)
    else $error("bus key removed a crosspoint");
  property p_shift_noset;
    sh_q >= QUIET |-> (xpoint & ~$past(xpoint)) == '0;
  endproperty
  a_shift_noset: assert property (p_shift_noset)
    else $error("crosspoint set while shift held");
  property p_late;
    (pb_q >= QUIET) ##1 pb_act |=> $stable(xpoint) [*4];
  endproperty
  a_late: assert property (p_late)
    else $error("crosspoints changed before key debounced");
  c_set: cover property (|(xpoint & ~$past(xpoint)));
  c_clr: cover property (sh_q >= QUIET && |($past(xpoint) & ~xpoint));
  c_led: cover property (|bus_led && |path_assigned_indicator);
endmodule : rcs_route_ctrl_asserts
bind rcs_route_ctrl rcs_route_ctrl_asserts #(
  .DEB_COUNT(DEB_COUNT),
  .FLASH_COUNT(FLASH_COUNT)
) u_chk (
  .clock(clock),
  .rst(rst),
  .path_key_raw(path_key_raw),
  .bus_key_raw(bus_key_raw),
  .shift_key_raw(shift_key_raw),
  .path_assigned_indicator(path_assigned_indicator),
  .bus_led(bus_led),
  .xpoint(xpoint)
);
`default_nettype wire

// ### rcs_key_panel.sv
`timescale 1ns/10ps
`default_nettype none
// front-panel keys; a released key reads not pressed
module rcs_key_panel
  import rcs_pkg::*;
#(
  parameter int DEB_COUNT = 4
) (
  input  wire logic                         clock,
  output logic      [rcs_pkg::NUM_PATH-1:0] path_key_raw,
  output logic      [rcs_pkg::NUM_BUS-1:0]  bus_key_raw,
  output logic                              shift_key_raw
);
  localparam int HOLD = DEB_COUNT + 8;
  // all keys up at time zero
  initial begin
    path_key_raw  = '0;
    bus_key_raw   = '0;
    shift_key_raw = 1'b0;
  end
  // outlast debounce, falling edges only
  task automatic settle;
    repeat (HOLD) @(negedge clock);
  endtask : settle
  // first keys down, second joins while first held, then all up
  task automatic tap(input logic [NUM_PATH-1:0] p1, input logic [NUM_BUS-1:0] b1,
                     input logic [NUM_PATH-1:0] p2, input logic [NUM_BUS-1:0] b2);
    path_key_raw = p1;
    bus_key_raw  = b1;
    settle();
    path_key_raw = p1 | p2;
    bus_key_raw  = b1 | b2;
    settle();
    path_key_raw = '0;
    bus_key_raw  = '0;
    settle();
  endtask : tap
  // shift key down or up
  task automatic set_shift(input logic v);
    shift_key_raw = v;
    settle();
  endtask : set_shift
endmodule : rcs_key_panel
`default_nettype wire

// ### tb_route_crosspoint_selector.sv
`timescale 1ns/10ps
`default_nettype none
module tb_route_crosspoint_selector;
  import rcs_pkg::*;
  localparam int DEB = 4;
  localparam int FLS = 8;
  logic                        clock = 1'b0;
  logic                        rst   = 1'b1;
  logic [NUM_PATH-1:0]         path_key_raw;
  logic [NUM_BUS-1:0]          bus_key_raw;
  logic                        shift_key_raw;
  logic [NUM_PATH-1:0]         path_assigned_indicator;
  logic [NUM_BUS-1:0]          bus_led;
  logic [NUM_PATH*NUM_BUS-1:0] xpoint;
  logic [NUM_PATH*NUM_BUS-1:0] exp_xp;
  int                          n_mismatch = 0;
  int                          checked = 0;
  int                          cyc = 0;
  // 20 MHz clock
  always #25 clock = ~clock;
  rcs_key_panel #(.DEB_COUNT(DEB)) kp (.clock(clock), .path_key_raw(path_key_raw),
    .bus_key_raw(bus_key_raw), .shift_key_raw(shift_key_raw));
  rcs_route_ctrl #(.DEB_COUNT(DEB), .FLASH_COUNT(FLS)) dut (.clock(clock), .rst(rst),
    .path_key_raw(path_key_raw), .bus_key_raw(bus_key_raw), .shift_key_raw(shift_key_raw),
    .path_assigned_indicator(path_assigned_indicator), .bus_led(bus_led), .xpoint(xpoint));
  task automatic complete_run;
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // crosspoint state against the expected map
  task automatic chk_xp;
    checked++;
    if (xpoint !== exp_xp) begin
      n_mismatch++;
      $display("Error at %0t: xpoint %h want %h", $time, xpoint, exp_xp);
    end
  endtask : chk_xp
  // lit cycles of one indicator over 32 cycles: 32 bright, 16 flash, 4 dim
  task automatic chk_led(input logic is_bus, input int idx, input logic [7:0] want);
    logic [7:0] cnt;
    cnt = '0;
    repeat (32) begin
      @(negedge clock);
      cnt = cnt + 8'(is_bus ? bus_led[idx] : path_assigned_indicator[idx]);
    end
    checked++;
    if (cnt !== want) begin
      n_mismatch++;
      $display("Error at %0t: led count %h want %h", $time, cnt, want);
    end
  endtask : chk_led
  // one path to two buses, then back to idle
  task automatic sc_path;
    kp.tap(32'h0000_0008, '0, '0, '0);
    chk_xp();
    chk_led(1'b0, 3, 8'h10);
    kp.tap('0, 16'h0020, '0, '0);
    kp.tap('0, 16'h0080, '0, '0);
    exp_xp[3*16+5] = 1'b1;
    exp_xp[3*16+7] = 1'b1;
    chk_xp();
    chk_led(1'b1, 5, 8'h20);
    kp.tap(32'h0000_0008, '0, '0, '0);
    chk_led(1'b1, 5, 8'h04);
    chk_led(1'b0, 3, 8'h04);
  endtask : sc_path
  // return path range to bus range, shift escapes
  task automatic sc_range;
    kp.tap(32'h0100_0000, '0, 32'h0400_0000, '0);
    chk_led(1'b0, 25, 8'h10);
    kp.tap('0, 16'h0001, '0, 16'h0008);
    for (int p = 24; p <= 26; p++) begin
      exp_xp[p*16 +: 4] = 4'hf;
    end
    chk_xp();
    kp.set_shift(1'b1);
    kp.set_shift(1'b0);
    chk_xp();
    chk_led(1'b0, 25, 8'h04);
  endtask : sc_range
  // bus selection toggles one path in and out
  task automatic sc_bus;
    kp.tap('0, 16'h0200, '0, '0);
    chk_led(1'b1, 9, 8'h10);
    kp.tap(32'h0000_0004, '0, '0, '0);
    exp_xp[2*16+9] = 1'b1;
    chk_xp();
    chk_led(1'b0, 2, 8'h20);
    kp.tap(32'h0000_0004, '0, '0, '0);
    exp_xp[2*16+9] = 1'b0;
    chk_xp();
    kp.tap('0, 16'h0200, '0, '0);
    chk_led(1'b1, 9, 8'h00);
  endtask : sc_bus
  // bus pair selected, path pair merged in, same bus pair ends
  task automatic sc_bus_range;
    kp.tap('0, 16'h0400, '0, 16'h0800);
    chk_led(1'b1, 11, 8'h10);
    kp.tap(32'h0000_0001, '0, 32'h0000_0080, '0);
    for (int p = 0; p <= 7; p++) begin
      exp_xp[p*16+10] = 1'b1;
      exp_xp[p*16+11] = 1'b1;
    end
    chk_xp();
    kp.tap('0, 16'h0400, '0, 16'h0800);
    chk_led(1'b1, 11, 8'h04);
    chk_led(1'b0, 7, 8'h04);
  endtask : sc_bus_range
  // shift held: clear one path row, then every bus
  task automatic sc_clear;
    kp.set_shift(1'b1);
    kp.tap(32'h0000_0008, '0, '0, '0);
    exp_xp[3*16 +: 16] = '0;
    chk_xp();
    kp.tap('0, 16'h0001, '0, 16'h8000);
    exp_xp = '0;
    chk_xp();
    kp.set_shift(1'b0);
    chk_led(1'b1, 0, 8'h00);
  endtask : sc_clear
  // main sequence
  initial begin
    exp_xp = '0;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    chk_xp();
    chk_led(1'b1, 0, 8'h00);
    sc_path();
    sc_range();
    sc_bus();
    sc_bus_range();
    sc_clear();
    complete_run();
  end
  // cycle ceiling against a hung run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end
endmodule : tb_route_crosspoint_selector
`default_nettype wire
